// >>> verilog/dmeir_pkg.sv
// Purpose: shared constants and carriers for interrogation and ranging
// Assumes: single 10 MHz clock, synchronous active-high reset
// Notes:   times kept in their own unit, cycle counts derived from them
package dmeir_pkg;
    // clock
    localparam int CLK_HZ        = 10_000_000;
    localparam int CLK_NS        = 1_000_000_000 / CLK_HZ;
    localparam int US_CYC        = 1000 / CLK_NS;
    // interrogation timing
    localparam int PAIR_RATE_HZ  = 30;
    localparam int PAIR_CYC      = CLK_HZ / PAIR_RATE_HZ;
    localparam int PER_W         = 19;
    localparam int TX_PW_NS      = 3500;
    localparam int TX_PW_CYC     = (TX_PW_NS + CLK_NS - 1) / CLK_NS;
    localparam int TX_SP_X_US    = 12;
    localparam int TX_SP_Y_US    = 36;
    localparam int TX_SP_X_CYC   = TX_SP_X_US * US_CYC;
    localparam int TX_SP_Y_CYC   = TX_SP_Y_US * US_CYC;
    localparam int BEACON_DLY_US = 50;
    localparam int DEAD_CYC      = BEACON_DLY_US * US_CYC;
    // reply decoding
    localparam int RX_SP_X_US    = 12;
    localparam int RX_SP_Y_US    = 30;
    localparam int RX_SP_X_CYC   = RX_SP_X_US * US_CYC;
    localparam int RX_SP_Y_CYC   = RX_SP_Y_US * US_CYC;
    localparam int RX_TOL_CYC    = 5;
    localparam int GAP_W         = 9;
    // ranging: round trip per tenth of a mile, 12.36 us per mile
    localparam int TENTH_NM_NS   = 1236;
    localparam int FRAC_W        = 11;
    localparam int RNG_W         = 12;
    localparam int RNG_TERM      = 2048;
    localparam int DIST_W        = 11;
    // reply validation
    localparam int GATE_TENTHS   = 5;
    localparam int CONFIRM       = 3;
    localparam int MISS_LIMIT    = 8;
    // channel plan
    localparam int CH_IDX_LAST   = 99;
    localparam int CH_LOW_LAST   = 42;
    localparam int TX_LOW_BASE   = 1041;
    localparam int TX_HIGH_BASE  = 1051;
    localparam int IF_MHZ        = 63;
    localparam int MHZ_W         = 11;

    // selected channel; synthesizer word is in 0.5 MHz units
    typedef struct packed {
        logic             valid;
        logic             is_y;
        logic [MHZ_W-1:0] tx_mhz;
        logic [MHZ_W-1:0] rx_mhz;
        logic [MHZ_W-1:0] synth_half_mhz;
    } dmeir_chan_s;

    // display carrier
    typedef struct packed {
        logic                     speed_and_time_view;
        logic                     dist_valid;
        logic [DIST_W-1:0]        dist_tenths;
        logic signed [DIST_W:0]   closure_tenths;
    } dmeir_view_s;
endpackage : dmeir_pkg

// >>> verilog/dmeir_chan_sel.sv
// Purpose: channel selection from panel digits or remote 2-of-5 lines
// Assumes: inputs synchronous to clk
// Notes:   output registered; invalid selection clears valid
`timescale 1ns/1ps
`default_nettype none
module dmeir_chan_sel
    import dmeir_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // panel selectors
    input  wire logic [3:0] pnl_mhz_digit,
    input  wire logic [3:0] pnl_tenth,
    input  wire logic       pnl_half,
    // remote channeling
    input  wire logic       rmt_sel,
    input  wire logic [4:0] rmt_mhz_code,
    input  wire logic [4:0] rmt_tenth_code,
    input  wire logic       rmt_half,
    // result
    output dmeir_chan_s     chan,
    output logic            chan_err
);
    // 2-of-5 line code to {ok, digit}
    function automatic logic [4:0] two_of_five(input logic [4:0] c);
        logic [4:0] r;
        r = 5'h00;
        case (c)
            5'b00011: r = 5'h10;
            5'b00101: r = 5'h11;
            5'b00110: r = 5'h12;
            5'b01001: r = 5'h13;
            5'b01010: r = 5'h14;
            5'b01100: r = 5'h15;
            5'b10001: r = 5'h16;
            5'b10010: r = 5'h17;
            5'b10100: r = 5'h18;
            5'b11000: r = 5'h19;
            default:  r = 5'h00;
        endcase
        return r;
    endfunction : two_of_five

    logic [4:0]       rm_d, rt_d;
    logic [3:0]       mhz, tenth;
    logic             half, ok;
    logic [6:0]       idx;
    logic [MHZ_W-1:0] tx;
    dmeir_chan_s      chan_d;
    logic             err_d;

    always_comb
    begin
        rm_d   = two_of_five(rmt_mhz_code);
        rt_d   = two_of_five(rmt_tenth_code);
        mhz    = rmt_sel ? rm_d[3:0] : pnl_mhz_digit;
        tenth  = rmt_sel ? rt_d[3:0] : pnl_tenth;
        half   = rmt_sel ? rmt_half : pnl_half;
        ok     = rmt_sel ? (rm_d[4] & rt_d[4]) : 1'b1;
        ok     = ok && (mhz <= 4'h9) && (tenth <= 4'h9);
        // digit 8,9 -> 108,109; 0..7 -> 110..117
        idx    = (mhz >= 4'h8) ? 7'(mhz - 4'h8) : 7'(mhz + 4'h2);
        idx    = 7'(idx * 7'd10 + 7'(tenth));
        ok     = ok && (idx <= 7'(CH_IDX_LAST));
        tx     = (idx <= 7'(CH_LOW_LAST)) ? MHZ_W'(TX_LOW_BASE + int'(idx))
                                          : MHZ_W'(TX_HIGH_BASE + int'(idx));
        chan_d.valid  = ok;
        chan_d.is_y   = half;
        chan_d.tx_mhz = tx;
        chan_d.rx_mhz = ((idx <= 7'(CH_LOW_LAST)) ^ half) ? MHZ_W'(tx - MHZ_W'(IF_MHZ))
                                                          : MHZ_W'(tx + MHZ_W'(IF_MHZ));
        // synthesizer at half the transmit frequency
        chan_d.synth_half_mhz = tx;
        err_d  = !ok;
    end

    // registered channel word
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            chan     <= '0;
            chan_err <= 1'b0;
        end
        else
        begin
            chan     <= chan_d;
            chan_err <= err_d;
        end
    end
endmodule : dmeir_chan_sel
`default_nettype wire

// >>> verilog/dmeir_ranging.sv
// Purpose: interrogation pair generation, reply decode and ranging
// Assumes: 10 MHz clock; rx_pulse is detected reply video, synchronous
// Notes:   distance in tenths of a nautical mile, held across misses
`timescale 1ns/1ps
`default_nettype none
module dmeir_ranging
    import dmeir_pkg::*;
#(
    parameter int PAIR_PERIOD = PAIR_CYC
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // channel selectors
    input  wire logic [3:0] pnl_mhz_digit,
    input  wire logic [3:0] pnl_tenth,
    input  wire logic       pnl_half,
    input  wire logic       rmt_sel,
    input  wire logic [4:0] rmt_mhz_code,
    input  wire logic [4:0] rmt_tenth_code,
    input  wire logic       rmt_half,
    // display mode
    input  wire logic       speed_and_time_view,
    // radio link
    output logic            tx_pulse,
    input  wire logic       rx_pulse,
    // results
    output dmeir_chan_s     chan,
    output logic            chan_err,
    output dmeir_view_s     view,
    output logic            meas_strobe
);
    typedef enum logic [2:0] {
        ST_TX     = 3'b001,
        ST_SEARCH = 3'b010,
        ST_DONE   = 3'b100
    } dmeir_state_e;

    localparam logic [PER_W-1:0]  PER_LAST = PER_W'(PAIR_PERIOD - 1);
    localparam logic [PER_W-1:0]  PW_P     = PER_W'(TX_PW_CYC);
    localparam logic [PER_W-1:0]  SPX_P    = PER_W'(TX_SP_X_CYC);
    localparam logic [PER_W-1:0]  SPY_P    = PER_W'(TX_SP_Y_CYC);
    localparam logic [PER_W-1:0]  DEAD_P   = PER_W'(DEAD_CYC);
    localparam logic [GAP_W-1:0]  GAP_MAX  = '1;
    localparam logic [FRAC_W-1:0] STEP_P   = FRAC_W'(CLK_NS);
    localparam logic [FRAC_W-1:0] TENTH_P  = FRAC_W'(TENTH_NM_NS);
    localparam logic [RNG_W-1:0]  TERM_P   = RNG_W'(RNG_TERM);

    // distance between two range readings
    function automatic logic [DIST_W-1:0] absdiff(input logic [DIST_W-1:0] a,
                                                  input logic [DIST_W-1:0] b);
        return (a > b) ? DIST_W'(a - b) : DIST_W'(b - a);
    endfunction : absdiff

    // channel source
    dmeir_chan_sel u_chan (
        .clk            (clk),
        .srst           (srst),
        .pnl_mhz_digit  (pnl_mhz_digit),
        .pnl_tenth      (pnl_tenth),
        .pnl_half       (pnl_half),
        .rmt_sel        (rmt_sel),
        .rmt_mhz_code   (rmt_mhz_code),
        .rmt_tenth_code (rmt_tenth_code),
        .rmt_half       (rmt_half),
        .chan           (chan),
        .chan_err       (chan_err)
    );

    logic [PER_W-1:0]  per_q, per_d, sp_q;
    logic              launch, y_q, y_d, en_q, en_d, tx_q, tx_d;
    dmeir_state_e      state_q, state_d;
    logic [FRAC_W-1:0] frac_q, frac_d, frac_sum;
    logic [RNG_W-1:0]  rng_q, rng_d;
    logic              tick, term;
    logic              rx_prev_q;
    logic [GAP_W-1:0]  gap_q, gap_d, rsp;
    logic              rise, pair_hit;
    logic [DIST_W-1:0] cand_q, cand_d, dist_q, dist_d;
    logic [1:0]        hits_q, hits_d;
    logic [3:0]        miss_q, miss_d;
    logic              locked_q, locked_d, dval_q, dval_d;
    logic              near, accept, meas_q, view_q;
    logic signed [DIST_W:0] clos_q, clos_d;

    // free-running pair period, launch at count zero
    always_comb
    begin
        per_d  = (per_q == PER_LAST) ? '0 : PER_W'(per_q + 1'b1);
        launch = (per_q == '0);
    end

    // spacing and channel latched at launch
    always_comb
    begin
        y_d  = launch ? chan.is_y : y_q;
        en_d = launch ? chan.valid : en_q;
        // two windows of 3.5 us each
        // enable taken straight from launch, so the first pulse is full width
        tx_d = en_d && ((per_q < PW_P) ||
                        ((per_q >= sp_q) && (per_q < PER_W'(sp_q + PW_P))));
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            per_q <= '0;
            y_q   <= 1'b0;
            en_q  <= 1'b0;
            sp_q  <= SPX_P;
            tx_q  <= 1'b0;
        end
        else
        begin
            per_q <= per_d;
            y_q   <= y_d;
            en_q  <= en_d;
            sp_q  <= y_d ? SPY_P : SPX_P;
            tx_q  <= tx_d;
        end
    end

    // fractional tick: 100 ns steps against 1236 ns per tenth
    always_comb
    begin
        frac_sum = FRAC_W'(frac_q + STEP_P);
        tick     = (state_q == ST_SEARCH) && (frac_sum >= TENTH_P);
        // terminal count of the search counters
        term     = (state_q == ST_SEARCH) && (rng_q == TERM_P);
    end

    // reply pair decoder on rising-edge spacing
    always_comb
    begin
        rise     = rx_pulse && !rx_prev_q;
        rsp      = y_q ? GAP_W'(RX_SP_Y_CYC) : GAP_W'(RX_SP_X_CYC);
        gap_d    = rise ? GAP_W'(1) : ((gap_q == GAP_MAX) ? gap_q : GAP_W'(gap_q + 1'b1));
        if (launch)
            gap_d = GAP_MAX;
        pair_hit = rise && (state_q == ST_SEARCH) && !term &&
                   (gap_q >= GAP_W'(rsp - GAP_W'(RX_TOL_CYC))) &&
                   (gap_q <= GAP_W'(rsp + GAP_W'(RX_TOL_CYC)));
    end

    // accept only a reply at a confirmed, stable range
    always_comb
    begin
        near   = (hits_q != 2'd0) &&
                 (absdiff(rng_q[DIST_W-1:0], cand_q) <= DIST_W'(GATE_TENTHS));
        // lone squitter never reaches the confirm count
        accept = pair_hit && near &&
                 (locked_q || (hits_q == 2'(CONFIRM - 1)));
    end

    // ranging state and counters
    always_comb
    begin
        state_d = state_q;
        frac_d  = frac_q;
        rng_d   = rng_q;
        unique case (state_q)
            ST_TX:
            begin
                // search opens one beacon delay after second pulse
                if (en_q && (per_q == PER_W'(sp_q + DEAD_P)))
                begin
                    state_d = ST_SEARCH;
                    frac_d  = '0;
                    rng_d   = '0;
                end
            end
            ST_SEARCH:
            begin
                frac_d = tick ? FRAC_W'(frac_sum - TENTH_P) : frac_sum;
                rng_d  = RNG_W'(rng_q + RNG_W'(tick));
                if (accept || term || (pair_hit && !locked_q))
                    state_d = ST_DONE;
            end
            ST_DONE:
            begin
                state_d = ST_DONE;
            end
        endcase
        if (launch)
        begin
            state_d = ST_TX;
            frac_d  = '0;
            rng_d   = '0;
        end
    end

    // validation, lock and distance
    always_comb
    begin
        cand_d   = cand_q;
        hits_d   = hits_q;
        locked_d = locked_q;
        miss_d   = miss_q;
        dist_d   = dist_q;
        dval_d   = dval_q;
        clos_d   = clos_q;
        if (pair_hit && !locked_q)
        begin
            cand_d = rng_q[DIST_W-1:0];
            hits_d = near ? 2'(hits_q + 1'b1) : 2'd1;
        end
        if (accept)
        begin
            // range ticks are tenths of a mile
            dist_d   = rng_q[DIST_W-1:0];
            cand_d   = rng_q[DIST_W-1:0];
            clos_d   = $signed({1'b0, rng_q[DIST_W-1:0]}) - $signed({1'b0, dist_q});
            locked_d = 1'b1;
            dval_d   = 1'b1;
            miss_d   = '0;
        end
        // miss keeps distance; lock dropped only after many
        if (term)
        begin
            miss_d = 4'(miss_q + 1'b1);
            if (miss_q == 4'(MISS_LIMIT - 1))
            begin
                locked_d = 1'b0;
                hits_d   = '0;
                dval_d   = 1'b0;
                miss_d   = '0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q   <= ST_TX;
            frac_q    <= '0;
            rng_q     <= '0;
            rx_prev_q <= 1'b0;
            gap_q     <= GAP_MAX;
            cand_q    <= '0;
            hits_q    <= '0;
            locked_q  <= 1'b0;
            miss_q    <= '0;
            dist_q    <= '0;
            dval_q    <= 1'b0;
            clos_q    <= '0;
            meas_q    <= 1'b0;
            view_q    <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            frac_q    <= frac_d;
            rng_q     <= rng_d;
            rx_prev_q <= rx_pulse;
            gap_q     <= gap_d;
            cand_q    <= cand_d;
            hits_q    <= hits_d;
            locked_q  <= locked_d;
            miss_q    <= miss_d;
            dist_q    <= dist_d;
            dval_q    <= dval_d;
            clos_q    <= clos_d;
            meas_q    <= accept;
            view_q    <= speed_and_time_view;
        end
    end

    // outputs; frequency view reads chan alongside distance
    assign tx_pulse                 = tx_q;
    assign meas_strobe              = meas_q;
    assign view = '{speed_and_time_view: view_q,
                    dist_valid:          dval_q,
                    dist_tenths:         dist_q,
                    closure_tenths:      clos_q};

    // checks
    localparam int A_SPX = TX_SP_X_CYC + 1;
    localparam int A_SPY = TX_SP_Y_CYC + 1;
    logic [7:0] hi_cnt_q;
    always_ff @(posedge clk)
    begin
        hi_cnt_q <= (srst || !tx_q) ? 8'h00 : 8'(hi_cnt_q + 1'b1);
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_pulse_width: assert property ($fell(tx_pulse) |-> hi_cnt_q == 8'(TX_PW_CYC))
        else $error("transmit pulse width wrong");
    a_pair_start: assert property (launch && chan.valid |=> tx_pulse)
        else $error("pair did not start at launch");
    a_spacing_x: assert property (launch && chan.valid && !chan.is_y |->
        ##[A_SPX:A_SPX] $rose(tx_pulse))
        else $error("x channel pair spacing wrong");
    a_spacing_y: assert property (launch && chan.valid && chan.is_y |->
        ##[A_SPY:A_SPY] $rose(tx_pulse))
        else $error("y channel pair spacing wrong");
    a_dead_time: assert property (state_q == ST_TX ##1 state_q == ST_SEARCH |->
        $past(per_q) == PER_W'(sp_q + DEAD_P))
        else $error("search opened at wrong time");
    a_tick_gap: assert property (tick |=> !tick [*8])
        else $error("range ticks too close");
    a_clear_launch: assert property (launch |=> rng_q == '0 && state_q == ST_TX)
        else $error("counters not cleared at launch");
    a_term_hold: assert property (term |=> $stable(dist_q) && !meas_strobe)
        else $error("terminal count changed distance");
    a_dist_cause: assert property ($changed(dist_q) |-> $past(accept))
        else $error("distance changed without accepted reply");
    a_meas_search: assert property (meas_strobe |-> $past(state_q) == ST_SEARCH)
        else $error("measurement outside search");

    c_accept: cover property (meas_strobe && view.dist_valid);
    c_miss:   cover property (term);
    c_lock:   cover property ($rose(locked_q));
    c_y_pair: cover property (launch && chan.valid && chan.is_y);
endmodule : dmeir_ranging
`default_nettype wire

// >>> tb/dmeir_beacon.sv
// Purpose: ground beacon model answering interrogation pairs
// Assumes: tx_pulse from the block, single clk domain
// Notes:   range, extra traffic and ident keying set by the bench
`timescale 1ns/1ps
`default_nettype none
module dmeir_beacon
    import dmeir_pkg::*;
(
    // clock
    input  wire logic        clk,
    // traffic control
    input  wire logic        is_y,
    input  wire logic        answer,
    input  wire logic        junk,
    input  wire logic        ident,
    input  wire logic [15:0] rng_cyc,
    // radio link
    input  wire logic        tx_pulse,
    output logic             rx_pulse = 1'b0
);
    int   since = 0;         // cycles since last transmitted rise
    int   t     = 1_000_000; // cycles since last complete pair
    int   n     = 0;         // pairs seen, varies the stray range
    int   cyc   = 0;
    int   rsp;
    int   jr;
    logic tx_d  = 1'b0;

    // high while tt lies inside a pulse of a reply pair at range r
    function automatic logic in_pair(input int tt, input int r, input int s);
        return (tt >= DEAD_CYC + r - s && tt < DEAD_CYC + r - s + TX_PW_CYC)
            || (tt >= DEAD_CYC + r && tt < DEAD_CYC + r + TX_PW_CYC);
    endfunction : in_pair

    // pair pickup and reply keying
    always @(posedge clk)
    begin
        rsp = is_y ? RX_SP_Y_CYC : RX_SP_X_CYC;
        // stray pair always starts 40 to 99 cycles after the true second pulse, so every one lies outside its gate
        jr = int'(rng_cyc) + rsp + 40 + (n * 37) % 60;
        tx_d <= tx_pulse;
        cyc <= cyc + 1;
        since <= (tx_pulse && !tx_d) ? 0 : since + 1;
        t <= t + 1;
        // fixed delay counted from the second pulse
        if (tx_pulse && !tx_d && since == (is_y ? TX_SP_Y_CYC : TX_SP_X_CYC) - 1)
        begin
            t <= 0;
            n <= n + 1;
        end
        // ident keying replaces replies, single spaced pulses
        if (ident)
            rx_pulse <= (cyc % 140) < TX_PW_CYC;
        else
            rx_pulse <= answer && (in_pair(t, rng_cyc, rsp) || (junk && in_pair(t, jr, rsp)));
    end
endmodule : dmeir_beacon
`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench for interrogation and ranging
// Assumes: short pair period, beacon model on the radio link
// Notes:   channel plan as table rows, ranging by hand-written tests
`timescale 1ns/1ps
`default_nettype none
module tb
    import dmeir_pkg::*;
;
    localparam int PER   = 3000;
    localparam int LIMIT = 99000;
    typedef struct packed {
        logic        sel;
        logic [4:0]  md;
        logic [4:0]  td;
        logic        half;
        logic [10:0] tx;
        logic [10:0] rx;
    } dmeir_row_s;
    logic        clk = 1'b0;
    logic        srst;
    logic        srst_l;
    dmeir_view_s view_l;
    logic [3:0]  pnl_mhz_digit;
    logic [3:0]  pnl_tenth;
    logic        pnl_half;
    logic        rmt_sel;
    logic [4:0]  rmt_mhz_code;
    logic [4:0]  rmt_tenth_code;
    logic        rmt_half;
    logic        view_sel;
    logic        tx_pulse;
    logic        rx_pulse;
    dmeir_chan_s chan;
    logic        chan_err;
    dmeir_view_s view;
    logic        meas_strobe;
    logic        is_y;
    logic        answer;
    logic        junk;
    logic        ident;
    logic [15:0] rng;
    int          error_cnt  = 0;
    int          num_checks = 0;
    int          cyc_cnt    = 0;
    int          n;
    int          w;
    int          sp;
    int          per;
    logic [10:0] held;
    // tx 0 marks a selection that must be refused
    dmeir_row_s  rows [11] = '{
        '{1'b0, 5'h08, 5'h00, 1'b0, 11'h411, 11'h3d2},
        '{1'b0, 5'h08, 5'h00, 1'b1, 11'h411, 11'h450},
        '{1'b0, 5'h02, 5'h02, 1'b0, 11'h43b, 11'h3fc},
        '{1'b0, 5'h02, 5'h03, 1'b1, 11'h446, 11'h407},
        '{1'b0, 5'h07, 5'h09, 1'b1, 11'h47e, 11'h43f},
        '{1'b0, 5'h03, 5'h03, 1'b0, 11'h450, 11'h48f},
        '{1'b0, 5'h00, 5'h00, 1'b1, 11'h425, 11'h464},
        '{1'b0, 5'h04, 5'h0a, 1'b0, 11'h000, 11'h000},
        '{1'b1, 5'h14, 5'h03, 1'b1, 11'h411, 11'h450},
        '{1'b1, 5'h0c, 5'h05, 1'b0, 11'h462, 11'h4a1},
        '{1'b1, 5'h07, 5'h03, 1'b0, 11'h000, 11'h000}};

    // design and far-side beacon
    dmeir_ranging #(.PAIR_PERIOD(PER)) dut_u (.clk(clk), .srst(srst),
        .pnl_mhz_digit(pnl_mhz_digit), .pnl_tenth(pnl_tenth), .pnl_half(pnl_half),
        .rmt_sel(rmt_sel), .rmt_mhz_code(rmt_mhz_code), .rmt_tenth_code(rmt_tenth_code),
        .rmt_half(rmt_half), .speed_and_time_view(view_sel), .tx_pulse(tx_pulse),
        .rx_pulse(rx_pulse), .chan(chan), .chan_err(chan_err), .view(view),
        .meas_strobe(meas_strobe));
    dmeir_beacon bcn_u (.clk(clk), .is_y(is_y), .answer(answer), .junk(junk),
        .ident(ident), .rng_cyc(rng), .tx_pulse(tx_pulse), .rx_pulse(rx_pulse));
    // long period and no replies, so an X channel search reaches terminal count
    dmeir_ranging #(.PAIR_PERIOD(26000)) dut_l (.clk(clk), .srst(srst_l),
        .pnl_mhz_digit(pnl_mhz_digit), .pnl_tenth(pnl_tenth), .pnl_half(pnl_half),
        .rmt_sel(rmt_sel), .rmt_mhz_code(rmt_mhz_code), .rmt_tenth_code(rmt_tenth_code),
        .rmt_half(rmt_half), .speed_and_time_view(view_sel), .tx_pulse(),
        .rx_pulse(1'b0), .chan(), .chan_err(), .view(view_l), .meas_strobe());

    // 10 MHz clock
    initial
    begin
        forever #(CLK_NS / 2) clk = ~clk;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    // hang guard
    always @(posedge clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == LIMIT)
        begin
            $display("ERROR timeout expected finish seen hang");
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] got);
        num_checks++;
        if (got !== e)
        begin
            $display("ERROR %s expected %0h seen %0h", nm, e, got);
            error_cnt++;
        end
    endtask : chk

    task automatic near(input string nm, input int e, input logic [10:0] got);
        num_checks++;
        if ($isunknown(got) || got > e + 1 || got + 1 < e)
        begin
            $display("ERROR %s expected %0d seen %0d", nm, e, got);
            error_cnt++;
        end
    endtask : near

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic do_reset;
        srst = 1'b1;
        repeat (10) tick();
        srst = 1'b0;
    endtask : do_reset

    task automatic set_pnl(input logic [3:0] md, input logic [3:0] td, input logic hf);
        rmt_sel = 1'b0;
        pnl_mhz_digit = md;
        pnl_tenth = td;
        pnl_half = hf;
    endtask : set_pnl

    // pulse width, pair spacing and pair period from transmitted rises
    task automatic meas_tx(output int pw, output int s, output int p);
        int   t[$];
        logic q = 1'b0;
        pw = 0;
        for (int i = 0; i < 2 * PER + 400; i++)
        begin
            if (tx_pulse === 1'b1 && !q)
                t.push_back(i);
            if (tx_pulse === 1'b1 && t.size() == 1)
                pw++;
            q = tx_pulse;
            tick();
        end
        s = t.size() > 2 ? t[1] - t[0] : -1;
        p = t.size() > 2 ? t[2] - t[0] : -1;
    endtask : meas_tx

    // count accepted replies, optionally stopping at the first
    task automatic watch(input int lim, input bit stop, output int c);
        c = 0;
        for (int i = 0; i < lim && !(stop && c > 0); i++)
        begin
            tick();
            if (meas_strobe === 1'b1)
                c++;
        end
    endtask : watch

    function automatic int exp_tenths(input logic [15:0] r);
        return (int'(r) * CLK_NS + TENTH_NM_NS / 2) / TENTH_NM_NS;
    endfunction : exp_tenths

    initial
    begin
        srst = 1'b1;
        srst_l = 1'b1;
        set_pnl(4'h8, 4'h0, 1'b0);
        rmt_mhz_code = 5'h00;
        rmt_tenth_code = 5'h00;
        rmt_half = 1'b0;
        view_sel = 1'b0;
        {is_y, answer, junk, ident} = 4'b0110;
        rng = 16'h007c;
        do_reset();
        srst_l = 1'b0;
        chk("rst_tx", 0, tx_pulse);
        chk("rst_view", 0, view != '0);
        chk("rst_valid", 0, chan.valid);
        // channel plan rows, panel and remote
        foreach (rows[i])
        begin
            rmt_sel = rows[i].sel;
            rmt_half = rows[i].half;
            pnl_half = rows[i].sel ? ~rows[i].half : rows[i].half;
            pnl_mhz_digit = rows[i].sel ? 4'h8 : rows[i].md[3:0];
            pnl_tenth = rows[i].sel ? 4'h0 : rows[i].td[3:0];
            rmt_mhz_code = rows[i].sel ? rows[i].md : 5'h00;
            rmt_tenth_code = rows[i].sel ? rows[i].td : 5'h00;
            tick();
            tick();
            chk("chan_valid", rows[i].tx != 0, chan.valid);
            chk("chan_err", rows[i].tx == 0, chan_err);
            if (rows[i].tx != 0)
            begin
                chk("tx_mhz", rows[i].tx, chan.tx_mhz);
                chk("rx_mhz", rows[i].rx, chan.rx_mhz);
                chk("is_y", rows[i].half, chan.is_y);
                chk("synth", rows[i].tx, chan.synth_half_mhz);
            end
        end
        // X channel, true reply plus stray pairs
        set_pnl(4'h8, 4'h0, 1'b0);
        do_reset();
        meas_tx(w, sp, per);
        chk("pulse_w", TX_PW_CYC, w);
        chk("x_space", TX_SP_X_CYC, sp);
        chk("period", PER, per);
        watch(7 * PER, 1'b1, n);
        chk("x_acq", 1, n);
        near("x_dist", exp_tenths(rng), view.dist_tenths);
        w = exp_tenths(rng);
        rng = 16'h0095;
        watch(2 * PER, 1'b1, n);
        chk("x_track", 1, n > 0);
        near("x_dist2", exp_tenths(rng), view.dist_tenths);
        near("x_clos", exp_tenths(rng) - w, view.closure_tenths[10:0]);
        held = view.dist_tenths;
        // unanswered pairs, then ident traffic only
        answer = 1'b0;
        watch(3 * PER, 1'b0, n);
        chk("miss_cnt", 0, n);
        chk("miss_dist", held, view.dist_tenths);
        chk("miss_vld", 1, view.dist_valid);
        {answer, ident} = 2'b11;
        watch(2 * PER, 1'b0, n);
        chk("ident_cnt", 0, n);
        ident = 1'b0;
        watch(2 * PER, 1'b1, n);
        chk("resume", 1, n);
        // display mode follows the selector
        view_sel = 1'b1;
        tick();
        chk("view_on", 1, view.speed_and_time_view);
        view_sel = 1'b0;
        tick();
        chk("view_off", 0, view.speed_and_time_view);
        // Y channel at a longer range
        set_pnl(4'h8, 4'h0, 1'b1);
        {is_y, rng} = {1'b1, 16'h00f7};
        do_reset();
        meas_tx(w, sp, per);
        chk("y_space", TX_SP_Y_CYC, sp);
        watch(7 * PER, 1'b1, n);
        chk("y_acq", 1, n);
        near("y_dist", exp_tenths(rng), view.dist_tenths);
        // refused selection sends nothing
        set_pnl(4'h4, 4'ha, 1'b0);
        repeat (500) tick();
        chk("bad_err", 1, chan_err);
        n = 0;
        repeat (PER + 10)
        begin
            tick();
            n += (tx_pulse === 1'b1);
        end
        chk("bad_tx", 0, n);
        // long-period instance: unanswered search runs out, nothing reported
        n = 0;
        for (int i = 0; i < 15000 && n == 0; i++)
        begin
            tick();
            n = int'(dut_l.term);
        end
        chk("l_term", 1, n);
        chk("l_valid", 0, view_l.dist_valid);
        chk("l_dist", 0, view_l.dist_tenths);
        test_done();
    end
endmodule : tb
`default_nettype wire
